// *** sdtc_pkg.sv ***
// Constants and types shared by the digital potentiometer tap control.
// Assumes a 10 MHz reference clock; nothing else is needed around it.
`default_nettype none
package sdtc_pkg;

    // Reference clock period and the settle time of a store access.
    localparam int CLK_PERIOD_NS = 100;
    localparam int NV_ACCESS_NS  = 1600;
    localparam int NV_ACCESS_CYC =
        (NV_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_W = $clog2(NV_ACCESS_CYC + 1);

    // Frame geometry and field positions of the command word.
    localparam int      FRAME_BITS = 24;
    localparam int      CNT_W      = 5;
    localparam int      TAP_W      = 8;
    localparam int      NV_W       = 9;
    localparam int      SLOTS      = 4;
    localparam int      BUF_BIT    = 8;
    localparam logic [7:0] TAP_MAX = 8'hFF;
    localparam logic [7:0] TAP_MIN = 8'h00;

    // Values after reset and the content of a blank store.
    localparam logic [7:0]  TAP_RST  = 8'h00;
    localparam logic [8:0]  NV_INIT  = 9'h080;
    localparam logic [23:0] WORD_RST = 24'h000000;

    // Command codes carried in the command_code_field.
    typedef enum logic [3:0] {
        SDTC_NOP      = 4'h0,
        SDTC_WR_TAP   = 4'h1,
        SDTC_RD_TAP   = 4'h2,
        SDTC_RD_NV    = 4'h4,
        SDTC_PROG_NV  = 4'h5,
        SDTC_LOAD_TAP = 4'h6,
        SDTC_SAVE_TAP = 4'h7,
        SDTC_INC      = 4'h8,
        SDTC_DEC      = 4'h9
    } sdtc_code_t;

    // One 24-bit serial command, most significant bit first.
    typedef struct packed {
        logic [3:0] command_code_field;
        logic       slot_select_high;
        logic       slot_select_low;
        logic       channel_select_high;
        logic       channel_select_low;
        logic [6:0] dont_care;
        logic [8:0] data;
    } sdtc_cmd_t;

endpackage
`default_nettype wire

// *** sdtc_top.sv ***
// Serial tap control of a 256-position digital potentiometer with a
// four-slot nonvolatile setting store. Assumes an external serial master
// on chip select, serial clock and data in, and an open-drain data out.
//
// How it works
// - Eight-bit tap selects one of 256 positions.
// - Wiper output comes only from tap register.
// - Tap loads from serial data or slot.
// - Save copies tap setting into selected slot.
// - Power-up recalls slot zero into tap.
// - Exactly four retained setting slots exist.
// - Output buffer enable follows stored configuration.
// - Deselected: ignore traffic, release output, standby once not busy.
// - Selected while chip select is low.
// - No operation before first chip select fall.
// - Serial input sampled on serial clock rise.
// - Read bits: first at select fall, then clock falls.
// - Shifted data passes out for daisy chains.
// - Write protect blocks store changes, allows recall.
// - Command is 24 bits, most significant first.
// - Two slot bits index slots zero to three.
// - Buffer bit acts only through slot load.
// - Increment and decrement saturate, never wrap.
`timescale 1ns/1ns
`default_nettype none

module sdtc_top (
    input  wire logic       I_REF_CLK,
    input  wire logic       I_RST,
    input  wire logic       I_CS_N,
    input  wire logic       I_SCLK,
    input  wire logic       I_SDI,
    input  wire logic       I_WP_N,
    output logic      [7:0] O_WIPER,
    output logic            O_BUF_EN,
    output logic            O_SDO_OUT,
    output logic            O_SDO_OE,
    output logic            O_BUSY,
    output logic            O_STANDBY
);

    // Synchroniser stages; the first stage feeds only the second.
    logic [3:0] meta_q;
    logic [3:0] sync_q;
    logic [1:0] prev_q;
    logic       cs_s;
    logic       sclk_s;
    logic       cs_fall;
    logic       cs_rise;
    logic       sclk_rise;
    logic       sclk_fall;

    // Serial shifter state.
    logic [23:0]            sr_q, sr_d;
    logic [sdtc_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic                   bit_q, bit_d;
    logic                   pend_q, pend_d;
    logic                   armed_q, armed_d;
    logic [23:0]            word;
    logic                   exec;

    // Core state.
    logic [7:0]              tap_q, tap_d;
    logic                    buf_q, buf_d;
    logic                    boot_q, boot_d;
    logic                    rd_q, rd_d;
    logic [23:0]             resp_q, resp_d;
    logic [sdtc_pkg::BUSY_W-1:0] busy_q, busy_d;
    // Retained cells are never reset; a blank part starts at NV_INIT.
    logic [8:0]              mem_q [0:sdtc_pkg::SLOTS-1] =
        '{default: sdtc_pkg::NV_INIT};
    logic                    mem_we;
    logic [1:0]              mem_idx;
    logic [8:0]              mem_wd;
    sdtc_pkg::sdtc_cmd_t     cmd;
    logic [1:0]              slot;
    logic                    wp_s;

    // Saturating step of the tap value, shared by both directions.
    function automatic logic [7:0] step(input logic [7:0] v,
                                        input logic       up);
        if (up) begin
            step = (v == sdtc_pkg::TAP_MAX) ? v : v + 8'h01;
        end else begin
            step = (v == sdtc_pkg::TAP_MIN) ? v : v - 8'h01;
        end
    endfunction

    // Pins come from the master's domain, so each passes two flops.
    // Chip select resets high so that reset itself makes no false fall.
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            meta_q <= 4'hD;
            sync_q <= 4'hD;
            prev_q <= 2'h1;
        end else begin
            meta_q <= {I_WP_N, I_SDI, I_SCLK, I_CS_N};
            sync_q <= meta_q;
            prev_q <= {sync_q[1], sync_q[0]};
        end
    end

    assign cs_s      = sync_q[0];
    assign sclk_s    = sync_q[1];
    assign cs_fall   = prev_q[0] && !cs_s;
    assign cs_rise   = !prev_q[0] && cs_s;
    assign sclk_rise = !prev_q[1] && sclk_s;
    assign sclk_fall = prev_q[1] && !sclk_s;
    assign wp_s      = sync_q[3];

    // Shifter next state. Input is taken on clock rises and moved into
    // the shifter on the following fall, so the outgoing bit changes
    // only on falls while the master samples on rises.
    always_comb begin
        sr_d    = sr_q;
        cnt_d   = cnt_q;
        bit_d   = bit_q;
        pend_d  = pend_q;
        armed_d = armed_q;
        word    = sr_q;
        exec    = 1'b0;
        if (cs_fall) begin
            armed_d = 1'b1;
            cnt_d   = '0;
            pend_d  = 1'b0;
            sr_d    = rd_q ? resp_q : sr_q;
        end else if (!cs_s) begin
            if (sclk_rise) begin
                bit_d  = sync_q[2];
                pend_d = 1'b1;
                if (cnt_q != '1) begin
                    cnt_d = cnt_q + 5'h01;
                end
            end
            if (sclk_fall && pend_q) begin
                sr_d   = {sr_q[22:0], bit_q};
                pend_d = 1'b0;
            end
        end
        if (cs_rise) begin
            word   = pend_q ? {sr_q[22:0], bit_q} : sr_q;
            sr_d   = word;
            pend_d = 1'b0;
            exec   = armed_q && !boot_q && (busy_q == '0)
                  && (cnt_q == 5'(sdtc_pkg::FRAME_BITS));
        end
    end

    // Shifter registers.
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            sr_q    <= sdtc_pkg::WORD_RST;
            cnt_q   <= '0;
            bit_q   <= 1'b0;
            pend_q  <= 1'b0;
            armed_q <= 1'b0;
        end else begin
            sr_q    <= sr_d;
            cnt_q   <= cnt_d;
            bit_q   <= bit_d;
            pend_q  <= pend_d;
            armed_q <= armed_d;
        end
    end

    assign cmd  = sdtc_pkg::sdtc_cmd_t'(word);
    assign slot = {cmd.slot_select_high, cmd.slot_select_low};

    // Command decoding. The buffer bit changes only when a slot is
    // loaded; a direct tap write leaves it alone.
    always_comb begin
        tap_d   = tap_q;
        buf_d   = buf_q;
        boot_d  = 1'b0;
        rd_d    = cs_fall ? 1'b0 : rd_q;
        resp_d  = resp_q;
        busy_d  = (busy_q != '0) ? busy_q - 1'b1 : busy_q;
        mem_we  = 1'b0;
        mem_idx = slot;
        mem_wd  = cmd.data;
        if (boot_q) begin
            tap_d  = mem_q[0][7:0];
            buf_d  = mem_q[0][sdtc_pkg::BUF_BIT];
            busy_d = sdtc_pkg::BUSY_W'(sdtc_pkg::NV_ACCESS_CYC);
        end else if (exec) begin
            case (cmd.command_code_field)
                sdtc_pkg::SDTC_WR_TAP: begin
                    tap_d = cmd.data[7:0];
                end
                sdtc_pkg::SDTC_RD_TAP: begin
                    rd_d   = 1'b1;
                    resp_d = {15'h0000, buf_q, tap_q};
                    busy_d = sdtc_pkg::BUSY_W'(sdtc_pkg::NV_ACCESS_CYC);
                end
                sdtc_pkg::SDTC_RD_NV: begin
                    rd_d   = 1'b1;
                    resp_d = {15'h0000, mem_q[slot]};
                    busy_d = sdtc_pkg::BUSY_W'(sdtc_pkg::NV_ACCESS_CYC);
                end
                sdtc_pkg::SDTC_PROG_NV: begin
                    mem_we = wp_s;
                    busy_d = sdtc_pkg::BUSY_W'(sdtc_pkg::NV_ACCESS_CYC);
                end
                sdtc_pkg::SDTC_LOAD_TAP: begin
                    tap_d  = mem_q[slot][7:0];
                    buf_d  = mem_q[slot][sdtc_pkg::BUF_BIT];
                    busy_d = sdtc_pkg::BUSY_W'(sdtc_pkg::NV_ACCESS_CYC);
                end
                sdtc_pkg::SDTC_SAVE_TAP: begin
                    mem_we = wp_s;
                    mem_wd = {buf_q, tap_q};
                    busy_d = sdtc_pkg::BUSY_W'(sdtc_pkg::NV_ACCESS_CYC);
                end
                sdtc_pkg::SDTC_INC: begin
                    tap_d = step(tap_q, 1'b1);
                end
                sdtc_pkg::SDTC_DEC: begin
                    tap_d = step(tap_q, 1'b0);
                end
                default: begin
                    tap_d = tap_q;
                end
            endcase
        end
    end

    // Core registers. The tap resets to a safe value and is then
    // overwritten from slot zero by the boot cycle.
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            tap_q  <= sdtc_pkg::TAP_RST;
            buf_q  <= 1'b0;
            boot_q <= 1'b1;
            rd_q   <= 1'b0;
            resp_q <= sdtc_pkg::WORD_RST;
            busy_q <= '0;
        end else begin
            tap_q  <= tap_d;
            buf_q  <= buf_d;
            boot_q <= boot_d;
            rd_q   <= rd_d;
            resp_q <= resp_d;
            busy_q <= busy_d;
        end
    end

    // Store writes. No reset here, since the cells stand for retained
    // content that must survive a power-up.
    always_ff @(posedge I_REF_CLK) begin
        if (mem_we) begin
            mem_q[mem_idx] <= mem_wd;
        end
    end

    // Outputs. The data pin only ever pulls low, and only while selected.
    assign O_WIPER   = tap_q;
    assign O_BUF_EN  = buf_q;
    assign O_SDO_OUT = 1'b0;
    assign O_SDO_OE  = !cs_s && !sr_q[23];
    assign O_BUSY    = (busy_q != '0) || boot_q;
    assign O_STANDBY = cs_s && !O_BUSY;

    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (I_RST);

    a_wiper_held: assert property (
        !exec && !boot_q |=> $stable(O_WIPER))
        else $error("wiper moved without a command");
    a_sdo_release: assert property (cs_s |-> !O_SDO_OE)
        else $error("data out driven while deselected");
    a_armed_first: assert property (exec |-> armed_q)
        else $error("command ran before first select fall");
    a_frame_len: assert property (
        exec |-> cnt_q == 5'(sdtc_pkg::FRAME_BITS))
        else $error("command ran on a wrong frame length");
    a_inc_sat: assert property (
        exec && cmd.command_code_field == sdtc_pkg::SDTC_INC
        && tap_q == sdtc_pkg::TAP_MAX |=> O_WIPER == sdtc_pkg::TAP_MAX)
        else $error("increment wrapped");
    a_dec_sat: assert property (
        exec && cmd.command_code_field == sdtc_pkg::SDTC_DEC
        && tap_q == sdtc_pkg::TAP_MIN |=> O_WIPER == sdtc_pkg::TAP_MIN)
        else $error("decrement wrapped");
    a_wp_store: assert property (mem_we |-> sync_q[3])
        else $error("store written while protected");
    a_boot_recall: assert property (
        boot_q |=> O_WIPER == mem_q[0][7:0] && O_BUSY)
        else $error("power-up recall missing");
    a_direct_buf: assert property (
        exec && cmd.command_code_field == sdtc_pkg::SDTC_WR_TAP
        |=> $stable(O_BUF_EN) && O_WIPER == $past(cmd.data[7:0]))
        else $error("direct write wrong or touched buffer bit");
    a_busy_after: assert property (
        exec && cmd.command_code_field == sdtc_pkg::SDTC_LOAD_TAP
        |=> O_BUSY [*3])
        else $error("busy missing after store access");
    a_save_copy: assert property (
        exec && cmd.command_code_field == sdtc_pkg::SDTC_SAVE_TAP
        && sync_q[3] |=> mem_q[$past(slot)] == $past({buf_q, tap_q}))
        else $error("save did not copy the tap setting");

    c_write: cover property (
        exec && cmd.command_code_field == sdtc_pkg::SDTC_WR_TAP);
    c_read: cover property (cs_fall && rd_q);
    c_save: cover property (
        exec && cmd.command_code_field == sdtc_pkg::SDTC_SAVE_TAP);
    c_inc_top: cover property (
        exec && cmd.command_code_field == sdtc_pkg::SDTC_INC
        && tap_q == sdtc_pkg::TAP_MAX);

endmodule

`default_nettype wire

// *** sdtc_master_model.sv ***
// Serial master model that frames commands into the tap control.
// Assumes the bench reference clock and a pulled-up data-out line.
`timescale 1ns/1ns
`default_nettype none

module sdtc_master_model (
    input  wire logic i_clk,
    output logic      o_cs_n,
    output logic      o_sclk,
    output logic      o_sdi,
    input  wire logic i_sdo
);
    // Idle state: deselected, with the serial clock parked low.
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_sdi  = 1'b1;
    end

    // Waits for a number of falling reference edges.
    task automatic waitn(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    // Every frame opens with a select fall, the first one too.
    // Sends the top nbits of word MSB first and collects the data out.
    // Data out is taken late in the high phase, which gives margin.
    task automatic xfer(input logic [23:0] word, input int nbits,
                        output logic [23:0] rx);
        rx = 24'h000000;
        waitn(1);
        o_cs_n = 1'b0;
        waitn(4);
        for (int i = 23; i > 23 - nbits; i--) begin
            o_sdi  = word[i];
            o_sclk = 1'b0;
            waitn(4);
            o_sclk = 1'b1;
            waitn(4);
            rx = {rx[22:0], i_sdo};
        end
        o_sclk = 1'b0;
        waitn(4);
        o_cs_n = 1'b1;
        o_sdi  = ~o_sdi; // A released line must not keep its old value.
        waitn(8);
    endtask
endmodule
`default_nettype wire

// *** sdtc_top_tb.sv ***
// Self-checking bench for the tap control, driven by the master model.
// Assumes the design package is compiled first.
`timescale 1ns/1ns
`default_nettype none

`define CHK(got, exp, msg) begin tests_run++; if ((got) !== (exp)) begin \
    fails++; $display("MISMATCH %0t %s", $time, msg); end end

module sdtc_top_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        wp_n = 1'b1;
    logic        cs_n, sclk, sdi, sdo, buf_en, sdo_out, sdo_oe, busy;
    logic        standby, was_busy;
    logic [7:0]  wiper;
    logic [8:0]  exp_q[$];
    logic [8:0]  last, tap, v;
    logic [8:0]  slots[4];
    logic [23:0] rx, w;
    integer      seed = 32'h398E;
    int          fails = 0;
    int          tests_run = 0;
    logic [3:0]  sc[6] = '{4'h1, 4'h8, 4'h9, 4'h1, 4'h9, 4'h8};
    logic [8:0]  sd[6] = '{9'h0FF, 9'h000, 9'h000, 9'h000, 9'h000, 9'h000};
    logic [8:0]  se[6] = '{9'h0FF, 9'h0FF, 9'h0FE, 9'h000, 9'h000, 9'h001};

    always #50 clk = ~clk;
    // Open-drain data out with a pull-up on the board.
    assign sdo = (sdo_oe === 1'b1) ? sdo_out : 1'b1;

    sdtc_top u_sdtc_top (.I_REF_CLK(clk), .I_RST(rst), .I_CS_N(cs_n),
        .I_SCLK(sclk), .I_SDI(sdi), .I_WP_N(wp_n), .O_WIPER(wiper),
        .O_BUF_EN(buf_en), .O_SDO_OUT(sdo_out), .O_SDO_OE(sdo_oe),
        .O_BUSY(busy), .O_STANDBY(standby));
    sdtc_master_model u_sdtc_master_model (.i_clk(clk), .o_cs_n(cs_n),
        .o_sclk(sclk), .o_sdi(sdi), .i_sdo(sdo));

    // Each visible change of wiper or buffer takes the oldest note.
    always @(negedge clk) begin
        if (rst) begin
            last <= 9'h000;
        end else if ({buf_en, wiper} !== last) begin
            last <= {buf_en, wiper};
            if (exp_q.size() == 0) begin
                `CHK(1'b1, 1'b0, "unexpected wiper change")
            end else begin
                `CHK({buf_en, wiper}, exp_q.pop_front(), "wiper")
            end
        end
    end

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Notes an expected setting; an unchanged value shows nothing.
    task automatic note(input logic [8:0] n);
        if (n !== tap) begin
            exp_q.push_back(n);
        end
        tap = n;
    endtask

    task automatic idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 100) begin
            @(negedge clk);
            n++;
        end
        if (n == 100) begin
            fails++;
            $display("MISMATCH %0t busy stuck", $time);
            test_done();
        end
    endtask

    // The master waits out the busy state before the next command.
    task automatic cmd(input logic [3:0] code, input logic [1:0] slot,
                       input logic [8:0] data);
        u_sdtc_master_model.xfer({code, slot, 9'h000, data}, 24, rx);
        was_busy = busy;
        idle();
    endtask

    // Main sequence: boot, writes, limits, framing, store and readback.
    initial begin
        repeat (12) @(negedge clk);
        tap = 9'h080;
        exp_q.push_back(9'h080);
        rst = 1'b0;
        repeat (20) @(negedge clk);
        idle();
        `CHK(standby, 1'b1, "standby")
        `CHK(sdo_oe, 1'b0, "sdo released")
        for (int i = 0; i < 6; i++) begin
            v = 9'($random(seed));
            note({tap[8], v[7:0]});
            cmd(4'h1, 2'b00, {1'b1, v[7:0]});
        end
        $display("test direct write done");
        for (int i = 0; i < 6; i++) begin
            note(se[i]);
            cmd(sc[i], 2'b00, sd[i]);
        end
        $display("test saturation done");
        u_sdtc_master_model.xfer({4'h1, 11'h000, 9'h055}, 23, rx);
        idle();
        `CHK(wiper, tap[7:0], "short frame ran")
        $display("test short frame done");
        for (int k = 0; k < 4; k++) begin
            v = 9'($random(seed));
            note({tap[8], v[7:0]});
            cmd(4'h1, 2'b00, {1'b0, v[7:0]});
            cmd(4'h7, k[1:0], 9'h000);
            `CHK(was_busy, 1'b1, "busy after save")
            slots[k] = tap;
        end
        for (int k = 3; k >= 0; k--) begin
            note(slots[k]);
            cmd(4'h6, k[1:0], 9'h000);
        end
        cmd(4'h5, 2'b10, 9'h1A5);
        slots[2] = 9'h1A5;
        note(9'h1A5);
        cmd(4'h6, 2'b10, 9'h000);
        note(9'h133);
        cmd(4'h1, 2'b00, 9'h033);
        $display("test store done");
        wp_n = 1'b0;
        cmd(4'h7, 2'b01, 9'h000);
        cmd(4'h5, 2'b11, 9'h111);
        note(slots[1]);
        cmd(4'h6, 2'b01, 9'h000);
        note(slots[3]);
        cmd(4'h6, 2'b11, 9'h000);
        wp_n = 1'b1;
        $display("test write protect done");
        cmd(4'h4, 2'b10, 9'h000);
        v = 9'($random(seed));
        w = {4'h0, v[3:0], 16'h5A3C ^ {7'h00, v}};
        u_sdtc_master_model.xfer(w, 24, rx);
        idle();
        `CHK(rx, {15'h0000, slots[2]}, "slot read")
        u_sdtc_master_model.xfer(24'h000000, 24, rx);
        idle();
        `CHK(rx, w, "chain out")
        // Tap readback: the answer comes out on the frame after the read.
        cmd(4'h2, 2'b00, 9'h000);
        u_sdtc_master_model.xfer(24'h000000, 24, rx);
        idle();
        `CHK(rx, {15'h0000, tap}, "tap read")
        `CHK(exp_q.size(), 0, "expected change missing")
        `CHK(standby, 1'b1, "standby at end")
        $display("test readback done");
        test_done();
    end

    // Guards the run against a hang anywhere.
    initial begin
        #5000000;
        fails++;
        $display("MISMATCH %0t run timeout", $time);
        test_done();
    end
endmodule
`default_nettype wire
